// [hw/mode_mapper_pkg.sv]
package mode_mapper_pkg;

    // register indices on the plain register port
    localparam logic [3:0] MODE_OFFSET = 4'h0;
    localparam logic [3:0] MFLEN_OFFSET = 4'h1;
    localparam logic [3:0] DEVID_OFFSET = 4'h2;
    localparam logic [3:0] CTRL_OFFSET = 4'h3;
    localparam logic [3:0] THR0_OFFSET = 4'h4;
    localparam logic [3:0] THR1_OFFSET = 4'h5;
    localparam logic [3:0] STATUS_OFFSET = 4'h6;
    localparam logic [3:0] CFG_OFFSET = 4'h7;
    localparam logic [3:0] KOUT_OFFSET = 4'h8;

    localparam int CTRL_ENABLE_BIT = 0;

    localparam logic [6:0] MODE_RESET = 7'h3b;
    localparam logic [7:0] MFLEN_RESET = 8'h1f;
    localparam logic [7:0] DEVID_RESET = 8'h00;
    localparam logic [14:0] THR_RESET = 15'h7fff;

    localparam int LANES_PER_LINK = 8;
    localparam int LANE_COUNT = 16;
    localparam int WORD_BITS = 16;
    localparam int LANE_BITS = 32;
    localparam logic [8:0] K_MAX = 9'h100;

    typedef enum logic [1:0] {
        LINK_OFF = 2'b00,
        LINK_INIT = 2'b01,
        LINK_RUN = 2'b11
    } link_state_type;

    typedef struct packed {
        logic valid;
        logic [5:0] decim;
        logic dual;
        logic [2:0] lanes;
        logic enc66;
        logic [2:0] octets;
        logic [1:0] emb;
        logic [8:0] kmin;
        logic [3:0] kstep;
        logic [7:0] ratio_x32;
    } mode_cfg_type;

    typedef struct packed {
        logic [14:0] i;
        logic [14:0] q;
    } sample_pair_type;

    typedef struct packed {
        logic [7:0] dev_id;
        logic [8:0] k_frames;
        mode_cfg_type cfg;
    } link_cfg_type;

    // per-mode transport table; ratio is bit rate over clock in 1/32 units
    function automatic mode_cfg_type mode_lookup(input logic [6:0] m);
        mode_cfg_type c;
        c = '0;
        case (m)
            7'h3b: c = '{1'b1, 6'h10, 1'b1, 3'h1, 1'b1, 3'h4, 2'h1, 9'h0, 4'h0, 8'h42};
            7'h3c: c = '{1'b1, 6'h10, 1'b1, 3'h2, 1'b1, 3'h2, 2'h1, 9'h0, 4'h0, 8'h21};
            7'h3d: c = '{1'b1, 6'h10, 1'b0, 3'h1, 1'b0, 3'h2, 2'h0, 9'h10, 4'h8, 8'h50};
            7'h3e: c = '{1'b1, 6'h10, 1'b0, 3'h2, 1'b0, 3'h2, 2'h0, 9'h10, 4'h8, 8'h28};
            7'h3f: c = '{1'b1, 6'h10, 1'b0, 3'h4, 1'b0, 3'h2, 2'h0, 9'h10, 4'h8, 8'h14};
            7'h40: c = '{1'b1, 6'h10, 1'b0, 3'h1, 1'b1, 3'h2, 2'h1, 9'h0, 4'h0, 8'h42};
            7'h41: c = '{1'b1, 6'h10, 1'b0, 3'h2, 1'b1, 3'h2, 2'h1, 9'h0, 4'h0, 8'h21};
            7'h42: c = '{1'b1, 6'h20, 1'b1, 3'h1, 1'b0, 3'h4, 2'h0, 9'h8, 4'h4, 8'h28};
            7'h43: c = '{1'b1, 6'h20, 1'b1, 3'h2, 1'b0, 3'h2, 2'h0, 9'h10, 4'h8, 8'h14};
            7'h44: c = '{1'b1, 6'h20, 1'b1, 3'h1, 1'b1, 3'h4, 2'h1, 9'h0, 4'h0, 8'h21};
            7'h45: c = '{1'b1, 6'h20, 1'b0, 3'h1, 1'b0, 3'h2, 2'h0, 9'h10, 4'h8, 8'h28};
            7'h46: c = '{1'b1, 6'h20, 1'b0, 3'h2, 1'b0, 3'h2, 2'h0, 9'h10, 4'h8, 8'h14};
            7'h47: c = '{1'b1, 6'h20, 1'b0, 3'h1, 1'b1, 3'h2, 2'h1, 9'h0, 4'h0, 8'h21};
            default: c = '0;
        endcase
        return c;
    endfunction

endpackage

// [hw/jesd_transport_mode_mapper.sv]
// Summary of operation
// - only listed modes are valid; any other select value disables the links
// - mode 59: dec16, dual, one lane, 64b/66b, four octets, E one, ratio 2.0625
// - mode 60: dec16, dual, two lanes, 64b/66b, two octets, E one, ratio 1.03125
// - modes 61-63: dec16 single 8b/10b, 1/2/4 lanes, K 16 to 256 step 8
// - modes 64-65: dec16 single 64b/66b two octets, one or two lanes
// - modes 66-67: dec32 dual 8b/10b, one or two lanes, K ranges differ
// - mode 68: dec32, dual, one lane, 64b/66b, four octets, E one, 1.03125
// - modes 69-70: dec32 single 8b/10b two octets, one or two lanes
// - mode 71: dec32, single, one lane, 64b/66b, two octets, ratio 1.03125
// - decimated sample words are 15 data bits plus one overrange bit
// - 64b/66b frame count K is derived as 256 times E over F
// - 8b/10b K comes from the programmed field and must respect mode range
// - converter count per link equals lanes so samples go out in time order, except dual one-lane modes, which put I and Q on one lane
// - sixteen lanes form two eight-lane links, both always used
// - only lowest lanes of each link run, higher lanes power down
// - link A carries the programmed device id, link B that plus one
// - undecimated 12-bit samples go out in offset binary
// - all tail bits are zero
// - samples are sent most significant bit first
// - channel A first overrange flag set above threshold zero, in dual modes only
// - second overrange flag per channel set above threshold one
`timescale 1ns/1ns
module jesd_transport_mode_mapper
    import mode_mapper_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [15:0] reg_rdata_o,
    input wire sample_pair_type chan_a_i,
    input wire sample_pair_type chan_b_i,
    input wire logic sample_valid_i,
    output logic [LANE_COUNT-1:0] lane_enable_o,
    output logic [LANE_COUNT-1:0][2:0] lane_identifier_o,
    output logic [LANE_COUNT-1:0][LANE_BITS-1:0] lane_data_o,
    output logic frame_valid_o,
    output link_cfg_type link_a_cfg_o,
    output link_cfg_type link_b_cfg_o,
    output logic link_restart_o,
    output logic chan_a_over_flag_first_o,
    output logic chan_a_over_flag_second_o,
    output logic chan_b_over_flag_first_o,
    output logic chan_b_over_flag_second_o
);

    logic [6:0] operating_mode_select;
    logic [6:0] active_mode;
    logic [7:0] multiframe_length_field;
    logic [7:0] device_identifier_field;
    logic link_enable;
    logic [14:0] overrange_threshold_zero;
    logic [14:0] overrange_threshold_one;
    link_state_type state;
    link_state_type next_state;
    logic [1:0] fill_count;
    logic [2:0][WORD_BITS-1:0] hold_a;
    logic [2:0][WORD_BITS-1:0] hold_b;

    function automatic logic [14:0] magnitude(input logic [14:0] s);
        return s[14] ? 15'(~s + 15'h0001) : s;
    endfunction

    // overrange bit rides in the lsb so the sample itself leaves msb first
    function automatic logic [WORD_BITS-1:0] fmt_word(input logic [14:0] s,
                                                      input logic flag,
                                                      input logic bypass);
        logic [WORD_BITS-1:0] w;
        w = {s, flag};
        if (bypass) begin
            w = {~s[14], s[13:3], 4'h0};
        end
        return w;
    endfunction

    wire mode_cfg_type cfg = mode_lookup(active_mode);
    wire mode_cfg_type pending_cfg = mode_lookup(operating_mode_select);
    wire bypass = (cfg.decim == 6'h01);

    // 64b/66b K is fixed by E and F; the programmed field is ignored there
    wire [8:0] k_base = {cfg.emb[0], 8'h00};
    wire [8:0] k_derived = (cfg.octets == 3'h4) ? (k_base >> 2) : (k_base >> 1);
    wire [8:0] k_programmed = 9'({1'b0, multiframe_length_field} + 9'h001);
    wire [8:0] k_effective = cfg.enc66 ? k_derived : k_programmed;
    wire [8:0] k_offset = 9'(k_programmed - cfg.kmin);
    wire k_step_bad = (cfg.kstep == 4'h8) ? (k_offset[2:0] != 3'h0) : (k_offset[1:0] != 2'h0);
    wire k_range_bad = !cfg.enc66 && cfg.valid
                       && ((k_programmed < cfg.kmin) || (k_programmed > K_MAX) || k_step_bad);

    wire mode_ok = cfg.valid && !k_range_bad;
    wire links_up = (state == LINK_RUN);

    // registers
    wire wr_mode = reg_write_i && (reg_addr_i == MODE_OFFSET);
    wire wr_mflen = reg_write_i && (reg_addr_i == MFLEN_OFFSET);
    wire wr_devid = reg_write_i && (reg_addr_i == DEVID_OFFSET);
    wire wr_ctrl = reg_write_i && (reg_addr_i == CTRL_OFFSET);
    wire wr_thr0 = reg_write_i && (reg_addr_i == THR0_OFFSET);
    wire wr_thr1 = reg_write_i && (reg_addr_i == THR1_OFFSET);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            operating_mode_select <= MODE_RESET;
            multiframe_length_field <= MFLEN_RESET;
            device_identifier_field <= DEVID_RESET;
            link_enable <= 1'b0;
            overrange_threshold_zero <= THR_RESET;
            overrange_threshold_one <= THR_RESET;
        end else begin
            if (wr_mode) begin
                operating_mode_select <= reg_wdata_i[6:0];
            end
            if (wr_mflen) begin
                multiframe_length_field <= reg_wdata_i[7:0];
            end
            if (wr_devid) begin
                device_identifier_field <= reg_wdata_i[7:0];
            end
            if (wr_ctrl) begin
                link_enable <= reg_wdata_i[CTRL_ENABLE_BIT];
            end
            if (wr_thr0) begin
                overrange_threshold_zero <= reg_wdata_i[14:0];
            end
            if (wr_thr1) begin
                overrange_threshold_one <= reg_wdata_i[14:0];
            end
        end
    end

    wire mode_pending = (operating_mode_select != active_mode);
    wire [15:0] status_word = {5'h0, k_range_bad, cfg.valid, mode_pending, state,
                               active_mode[5:0]};
    wire [15:0] cfg_word = {cfg.enc66, cfg.dual, cfg.lanes, cfg.octets, cfg.ratio_x32};
    wire [15:0] kout_word = {7'h0, k_effective};

    logic [15:0] read_mux;
    always_comb begin
        case (reg_addr_i)
            MODE_OFFSET: read_mux = {9'h0, operating_mode_select};
            MFLEN_OFFSET: read_mux = {8'h0, multiframe_length_field};
            DEVID_OFFSET: read_mux = {8'h0, device_identifier_field};
            CTRL_OFFSET: read_mux = {15'h0, link_enable};
            THR0_OFFSET: read_mux = {1'b0, overrange_threshold_zero};
            THR1_OFFSET: read_mux = {1'b0, overrange_threshold_one};
            STATUS_OFFSET: read_mux = status_word;
            CFG_OFFSET: read_mux = cfg_word;
            KOUT_OFFSET: read_mux = kout_word;
            default: read_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_read_i) begin
            reg_rdata_o <= read_mux;
        end
    end

    // link sequencing: a mode change is only adopted while both links are off
    always_comb begin
        next_state = state;
        case (state)
            LINK_OFF: begin
                if (link_enable && pending_cfg.valid && !mode_pending) begin
                    next_state = LINK_INIT;
                end
            end
            LINK_INIT: next_state = link_enable ? LINK_RUN : LINK_OFF;
            LINK_RUN: begin
                if (!link_enable || !mode_ok) begin
                    next_state = LINK_OFF;
                end
            end
            default: next_state = LINK_OFF;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= LINK_OFF;
            active_mode <= MODE_RESET;
            link_restart_o <= 1'b0;
        end else begin
            state <= next_state;
            link_restart_o <= (state == LINK_OFF) && (next_state == LINK_INIT);
            if (state == LINK_OFF) begin
                active_mode <= operating_mode_select;
            end
        end
    end

    // overrange detection on both I and Q magnitudes
    wire [14:0] mag_ai = magnitude(chan_a_i.i);
    wire [14:0] mag_aq = magnitude(chan_a_i.q);
    wire [14:0] mag_bi = magnitude(chan_b_i.i);
    wire [14:0] mag_bq = magnitude(chan_b_i.q);
    wire [14:0] peak_a = (mag_ai > mag_aq) ? mag_ai : mag_aq;
    wire [14:0] peak_b = (mag_bi > mag_bq) ? mag_bi : mag_bq;
    wire flag_a0 = cfg.dual && (peak_a > overrange_threshold_zero);
    wire flag_a1 = peak_a > overrange_threshold_one;
    wire flag_b0 = peak_b > overrange_threshold_zero;
    wire flag_b1 = peak_b > overrange_threshold_one;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chan_a_over_flag_first_o <= 1'b0;
            chan_a_over_flag_second_o <= 1'b0;
            chan_b_over_flag_first_o <= 1'b0;
            chan_b_over_flag_second_o <= 1'b0;
        end else if (sample_valid_i) begin
            chan_a_over_flag_first_o <= flag_a0;
            chan_a_over_flag_second_o <= flag_a1;
            chan_b_over_flag_first_o <= flag_b0;
            chan_b_over_flag_second_o <= flag_b1;
        end
    end

    // dual: link A carries channel A I/Q, link B channel B I/Q
    // single: link A carries I, link B carries Q, spread over lanes in time order
    wire [WORD_BITS-1:0] word_ai = fmt_word(chan_a_i.i, flag_a0, bypass);
    wire [WORD_BITS-1:0] word_aq = fmt_word(chan_a_i.q, flag_a1, bypass);
    wire [WORD_BITS-1:0] word_bi = fmt_word(chan_b_i.i, flag_b0, bypass);
    wire [WORD_BITS-1:0] word_bq = fmt_word(chan_b_i.q, flag_b1, bypass);
    wire [1:0] last_slot = 2'(cfg.lanes - 3'h1);
    wire take = links_up && sample_valid_i;
    wire frame_done = take && (cfg.dual || (fill_count == last_slot));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fill_count <= 2'h0;
            hold_a <= '0;
            hold_b <= '0;
        end else if (!links_up || frame_done) begin
            fill_count <= 2'h0;
        end else if (take) begin
            hold_a[fill_count] <= word_ai;
            hold_b[fill_count] <= word_aq;
            fill_count <= 2'(fill_count + 2'h1);
        end
    end

    // word k of a group goes to lane k, so no lane waits on another
    logic [LANE_COUNT-1:0][LANE_BITS-1:0] next_lane_data;
    always_comb begin
        next_lane_data = '0;
        if (cfg.dual && cfg.lanes == 3'h1) begin
            next_lane_data[0] = {word_ai, word_aq};
            next_lane_data[LANES_PER_LINK] = {word_bi, word_bq};
        end else if (cfg.dual) begin
            next_lane_data[0] = {word_ai, 16'h0000};
            next_lane_data[1] = {word_aq, 16'h0000};
            next_lane_data[LANES_PER_LINK] = {word_bi, 16'h0000};
            next_lane_data[LANES_PER_LINK+1] = {word_bq, 16'h0000};
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (k < int'(last_slot)) begin
                    next_lane_data[k] = {hold_a[k], 16'h0000};
                    next_lane_data[LANES_PER_LINK+k] = {hold_b[k], 16'h0000};
                end
            end
            next_lane_data[last_slot] = {word_ai, 16'h0000};
            next_lane_data[LANES_PER_LINK+int'(last_slot)] = {word_aq, 16'h0000};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lane_data_o <= '0;
            frame_valid_o <= 1'b0;
        end else begin
            frame_valid_o <= frame_done;
            if (frame_done) begin
                lane_data_o <= next_lane_data;
            end
        end
    end

    // lanes and identifiers
    always_comb begin
        for (int n = 0; n < LANE_COUNT; n++) begin
            lane_identifier_o[n] = 3'(n % LANES_PER_LINK);
            lane_enable_o[n] = (state != LINK_OFF) && cfg.valid
                               && ((n % LANES_PER_LINK) < int'(cfg.lanes));
        end
    end

    always_comb begin
        link_a_cfg_o.dev_id = device_identifier_field;
        link_a_cfg_o.k_frames = k_effective;
        link_a_cfg_o.cfg = cfg;
        link_b_cfg_o.dev_id = 8'(device_identifier_field + 8'h01);
        link_b_cfg_o.k_frames = k_effective;
        link_b_cfg_o.cfg = cfg;
    end

endmodule

// [tb/mode_mapper_chk.sv]
`timescale 1ns/1ns
module mode_mapper_chk
    import mode_mapper_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sample_valid_i,
    input wire logic [LANE_COUNT-1:0] lane_enable_o,
    input wire logic [LANE_COUNT-1:0][2:0] lane_identifier_o,
    input wire logic [LANE_COUNT-1:0][LANE_BITS-1:0] lane_data_o,
    input wire logic frame_valid_o,
    input wire link_cfg_type link_a_cfg_o,
    input wire link_cfg_type link_b_cfg_o,
    input wire logic link_restart_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_restart;
        link_restart_o |=> !link_restart_o && lane_enable_o[0] && lane_enable_o[8];
    endproperty
    a_restart: assert property (p_restart) else $error("no run after restart");
    property p_ids;
        lane_identifier_o == {2{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}};
    endproperty
    a_ids: assert property (p_ids) else $error("lane id wrong");
    property p_devid;
        link_b_cfg_o.dev_id == link_a_cfg_o.dev_id + 8'h01;
    endproperty
    a_devid: assert property (p_devid) else $error("link b id wrong");
    // a gap in the enabled lanes would strand data on a lane the receiver ignores
    property p_lowest;
        ((lane_enable_o[7:0] + 8'h01) & lane_enable_o[7:0]) == 8'h00
            && lane_enable_o[7:0] == lane_enable_o[15:8];
    endproperty
    a_lowest: assert property (p_lowest) else $error("lanes not lowest");
    property p_count;
        lane_enable_o != 16'h0000 |->
            $countones(lane_enable_o[7:0]) == int'(link_a_cfg_o.cfg.lanes);
    endproperty
    a_count: assert property (p_count) else $error("lane count wrong");
    property p_kderived;
        link_a_cfg_o.cfg.valid && link_a_cfg_o.cfg.enc66 |->
            int'(link_a_cfg_o.k_frames) * int'(link_a_cfg_o.cfg.octets)
            == 256 * int'(link_a_cfg_o.cfg.emb);
    endproperty
    a_kderived: assert property (p_kderived) else $error("derived k wrong");
    property p_frame;
        frame_valid_o |-> $past(sample_valid_i);
    endproperty
    a_frame: assert property (p_frame) else $error("frame without sample");
    property p_tail;
        frame_valid_o && link_a_cfg_o.cfg.octets == 3'h2 |->
            lane_data_o[0][15:0] == 16'h0000 && lane_data_o[8][15:0] == 16'h0000;
    endproperty
    a_tail: assert property (p_tail) else $error("tail bits set");
    property p_dark;
        !link_a_cfg_o.cfg.valid |-> lane_enable_o == 16'h0000;
    endproperty
    a_dark: assert property (p_dark) else $error("lanes on in bad mode");
endmodule
bind jesd_transport_mode_mapper mode_mapper_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .sample_valid_i(sample_valid_i), .lane_enable_o(lane_enable_o),
    .lane_identifier_o(lane_identifier_o), .lane_data_o(lane_data_o),
    .frame_valid_o(frame_valid_o), .link_a_cfg_o(link_a_cfg_o),
    .link_b_cfg_o(link_b_cfg_o), .link_restart_o(link_restart_o));

// [tb/rx_model.sv]
`timescale 1ns/1ns
module rx_model
    import mode_mapper_pkg::*;
(
    input wire logic clk_i,
    input wire logic [LANE_COUNT-1:0] lane_enable_i,
    input wire logic [LANE_COUNT-1:0][LANE_BITS-1:0] lane_data_i,
    input wire logic frame_valid_i,
    output logic [59:0] stream_o
);
    // lanes are read from zero upward and interleaved back into time order
    always_ff @(posedge clk_i) begin
        if (frame_valid_i) begin
            for (int k = 0; k < 4; k++) begin
                stream_o[59-15*k -: 15] <= lane_enable_i[k] ? lane_data_i[k][31:17] : 15'h0;
            end
        end
    end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ns
module tb
    import mode_mapper_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i, reg_write_i, reg_read_i, sample_valid_i, frame_valid_o, link_restart_o;
    logic [3:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, d, cfgv;
    sample_pair_type chan_a_i, chan_b_i;
    logic [LANE_COUNT-1:0] lane_enable_o;
    logic [LANE_COUNT-1:0][LANE_BITS-1:0] lane_data_o;
    link_cfg_type link_a_cfg_o, link_b_cfg_o;
    logic fa1, fa2, fb1, fb2, dual;
    logic [59:0] rx_stream;
    logic [14:0] ai [4], aq [4], bi [4], bq [4];
    logic [31:0] seed = 32'h8b84dc05;
    logic [31:0] r;
    int n_errors = 0, samples_checked = 0, m, n, k, j;
    logic [3:0] ra [5] = '{MODE_OFFSET, MFLEN_OFFSET, DEVID_OFFSET, THR0_OFFSET, 4'hf};
    logic [15:0] rv [5] = '{16'h003b, 16'h001f, 16'h0000, 16'h7fff, 16'h0000};
    int bad [2] = '{58, 72};
    sample_pair_type fa [2] = '{'{15'h01f4, 15'h7fec}, '{15'h0064, 15'h0000}};
    sample_pair_type fb [2] = '{'{15'h0003, 15'h7830}, '{15'h03e8, 15'h0000}};
    logic [3:0] fe [2] = '{4'hb, 4'h2};
    always #5 clk_i = ~clk_i;
    jesd_transport_mode_mapper dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .chan_a_i(chan_a_i), .chan_b_i(chan_b_i),
        .sample_valid_i(sample_valid_i), .lane_enable_o(lane_enable_o),
        .lane_identifier_o(), .lane_data_o(lane_data_o), .frame_valid_o(frame_valid_o),
        .link_a_cfg_o(link_a_cfg_o), .link_b_cfg_o(link_b_cfg_o),
        .link_restart_o(link_restart_o), .chan_a_over_flag_first_o(fa1),
        .chan_a_over_flag_second_o(fa2), .chan_b_over_flag_first_o(fb1),
        .chan_b_over_flag_second_o(fb2));
    rx_model rx (.clk_i(clk_i), .lane_enable_i(lane_enable_o), .lane_data_i(lane_data_o),
        .frame_valid_i(frame_valid_o), .stream_o(rx_stream));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // the most negative value has no positive twin, so the sample generator skips it
    function automatic logic [14:0] rsamp();
        logic [31:0] v;
        v = rnd();
        return (v[14:0] == 15'h4000) ? 15'h0000 : v[14:0];
    endfunction
    function automatic logic [15:0] exp_cfg(input int m);
        case (m)
            59: return {2'h3, 3'h1, 3'h4, 8'h42};
            60: return {2'h3, 3'h2, 3'h2, 8'h21};
            61: return {2'h0, 3'h1, 3'h2, 8'h50};
            62: return {2'h0, 3'h2, 3'h2, 8'h28};
            63: return {2'h0, 3'h4, 3'h2, 8'h14};
            64: return {2'h2, 3'h1, 3'h2, 8'h42};
            65: return {2'h2, 3'h2, 3'h2, 8'h21};
            66: return {2'h1, 3'h1, 3'h4, 8'h28};
            67: return {2'h1, 3'h2, 3'h2, 8'h14};
            68: return {2'h3, 3'h1, 3'h4, 8'h21};
            69: return {2'h0, 3'h1, 3'h2, 8'h28};
            70: return {2'h0, 3'h2, 3'h2, 8'h14};
            default: return {2'h2, 3'h1, 3'h2, 8'h21};
        endcase
    endfunction
    function automatic logic [31:0] exp_lane(input int j, input logic dual, input int n);
        logic [14:0] v;
        if (dual && n == 1) return (j < 8) ? {ai[0], 1'b0, aq[0], 1'b0} : {bi[0], 1'b0, bq[0], 1'b0};
        if (dual) v = (j < 8) ? ((j % 8 == 0) ? ai[0] : aq[0]) : ((j % 8 == 0) ? bi[0] : bq[0]);
        else v = (j < 8) ? ai[j % 8] : aq[j % 8];
        return {v, 1'b0, 16'h0000};
    endfunction
    task automatic results();
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t reg got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_lane(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t lane got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_flag(input logic [3:0] g, input logic [3:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t flag got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 v = reg_rdata_o;
        @(posedge clk_i);
    endtask
    // sel low waits for the restart pulse, sel high for a new frame
    task automatic wait_hi(input logic sel);
        int i;
        for (i = 0; i < 8; i++) begin
            #1;
            if ((sel ? frame_valid_o : link_restart_o) === 1'b1) break;
            @(posedge clk_i);
        end
        if (i == 8) begin
            n_errors++;
            results();
        end
        @(posedge clk_i);
    endtask
    initial begin
        rst_i = 1'b1;
        reg_addr_i = 4'h0;
        reg_wdata_i = 16'h0000;
        reg_write_i = 1'b0;
        reg_read_i = 1'b0;
        chan_a_i = '0;
        chan_b_i = '0;
        sample_valid_i = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ra[i]) begin
            rd(ra[i], d);
            chk_reg(d, rv[i]);
        end
        foreach (bad[i]) begin
            wr(MODE_OFFSET, 16'(bad[i]));
            wr(CTRL_OFFSET, 16'h0001);
            repeat (3) @(posedge clk_i);
            rd(STATUS_OFFSET, d);
            chk_reg(d & 16'h02c0, 16'h0000);
            wr(CTRL_OFFSET, 16'h0000);
        end
        wr(MODE_OFFSET, 16'd61);
        wr(MFLEN_OFFSET, 16'h0013);
        rd(STATUS_OFFSET, d);
        chk_reg(d & 16'h0400, 16'h0400);
        for (m = 59; m <= 71; m++) begin
            cfgv = exp_cfg(m);
            n = int'(cfgv[13:11]);
            dual = cfgv[14];
            r = rnd();
            k = (m == 66) ? 8 + 4 * int'(r[15:0] % 63) : 16 + 8 * int'(r[15:0] % 31);
            if (m == 63) k = 256;
            wr(MODE_OFFSET, 16'(m));
            wr(MFLEN_OFFSET, 16'(k - 1));
            wr(DEVID_OFFSET, {8'h00, r[23:16]});
            rd(CFG_OFFSET, d);
            chk_reg(d, cfgv);
            d = {r[23:16], 8'(r[23:16] + 8'h01)};
            chk_reg({link_a_cfg_o.dev_id, link_b_cfg_o.dev_id}, d);
            rd(KOUT_OFFSET, d);
            chk_reg(d, cfgv[15] ? (cfgv[10:8] == 3'h4 ? 16'h0040 : 16'h0080) : 16'(k));
            wr(CTRL_OFFSET, 16'h0001);
            wait_hi(1'b0);
            #1 chk_reg(lane_enable_o, {2{8'((1 << n) - 1)}});
            @(posedge clk_i);
            rd(STATUS_OFFSET, d);
            chk_reg(d & 16'h00c0, 16'h00c0);
            ai = '{default: '0};
            for (j = 0; j < (dual ? 1 : n); j++) begin
                ai[j] = rsamp();
                aq[j] = rsamp();
                bi[j] = rsamp();
                bq[j] = rsamp();
                chan_a_i <= '{ai[j], aq[j]};
                chan_b_i <= '{bi[j], bq[j]};
                sample_valid_i <= 1'b1;
                @(posedge clk_i);
            end
            sample_valid_i <= 1'b0;
            wait_hi(1'b1);
            for (j = 0; j < 16; j++) begin
                if (j % 8 < n) chk_lane(lane_data_o[j], exp_lane(j, dual, n));
            end
            #1;
            for (j = 0; j < 4 && !dual; j++) begin
                chk_lane({17'h0, rx_stream[59-15*j -: 15]}, {17'h0, ai[j]});
            end
            @(posedge clk_i);
            wr(CTRL_OFFSET, 16'h0000);
        end
        wr(MODE_OFFSET, 16'h003b);
        wr(THR0_OFFSET, 16'h0064);
        wr(THR1_OFFSET, 16'h03e8);
        wr(CTRL_OFFSET, 16'h0001);
        wait_hi(1'b0);
        // a mode written while running must wait until the links are off
        wr(MODE_OFFSET, 16'd61);
        rd(STATUS_OFFSET, d);
        chk_reg(d & 16'h01c0, 16'h01c0);
        rd(CFG_OFFSET, d);
        chk_reg(d, exp_cfg(59));
        wr(MODE_OFFSET, 16'h003b);
        for (j = 0; j < 2; j++) begin
            chan_a_i <= fa[j];
            chan_b_i <= fb[j];
            sample_valid_i <= 1'b1;
            @(posedge clk_i);
            sample_valid_i <= 1'b0;
            #1 chk_flag({fa1, fa2, fb1, fb2}, fe[j]);
            chk_lane(lane_data_o[0], {fa[j].i, fe[j][3], fa[j].q, fe[j][2]});
            chk_lane(lane_data_o[8], {fb[j].i, fe[j][1], fb[j].q, fe[j][0]});
            @(posedge clk_i);
        end
        results();
    end
endmodule
